// ===== include/ecpcr_defs.vh
// Purpose: constants of the extended parallel port control block
// Assumes: included once per file through its guard
// Notes:   offsets are port-relative byte addresses
`ifndef ECPCR_DEFS_VH
`define ECPCR_DEFS_VH
// Register offsets within the upper port window
`define ECPCR_OFS_FIFO      3'h0
`define ECPCR_OFS_CFGB      3'h1
`define ECPCR_OFS_ECR       3'h2
// Offsets within the lower port window
`define ECPCR_OFS_DATA      3'h0
`define ECPCR_OFS_CTRL      3'h2
// Mode codes
`define ECPCR_MODE_STD      3'h0
`define ECPCR_MODE_BIDIR    3'h1
`define ECPCR_MODE_FIFO     3'h2
`define ECPCR_MODE_ECP      3'h3
`define ECPCR_MODE_TEST     3'h6
`define ECPCR_MODE_CONFIG   3'h7
// Extended control field positions
`define ECPCR_ECR_FAULTN    4
`define ECPCR_ECR_BLOCK_TRANSFER_ENABLE     3
`define ECPCR_ECR_SERV      2
`define ECPCR_ECR_FULL      1
`define ECPCR_ECR_EMPTY     0
// Reset read value of the extended control register, empty flag included
`define ECPCR_ECR_RESET     8'h15
// Control register field positions
`define ECPCR_DCR_DIR       5
`define ECPCR_DCR_ACKIE     4
`define ECPCR_DCR_AUTOFD    1
`define ECPCR_DCR_STROBE    0
// Configuration words
`define ECPCR_CFG_A         8'h10
`define ECPCR_CFG_B         8'h00
// FIFO geometry and thresholds
`define ECPCR_FIFO_DEPTH    16
`define ECPCR_FIFO_AW       4
`define ECPCR_CNT_W         5
`define ECPCR_WR_THRESH     5'h08
`define ECPCR_RD_THRESH     5'h08
// Longest run of consecutive DMA requests
`define ECPCR_DMA_BURST     6'h20
`endif

// ===== src/ecpcr_fifo.v
// Purpose: byte FIFO shared by both transfer directions
// Assumes: one clock, synchronous clear
// Notes:   a read of an empty FIFO keeps the last byte on the output
`timescale 1ns/1ps
`include "ecpcr_defs.vh"
module ecpcr_fifo (
  // Clock and reset
  input  wire                      clk_in,
  input  wire                      rst_in,
  input  wire                      clear_in,
  // Write side
  input  wire                      push_in,
  input  wire [7:0]                wdata_in,
  // Read side
  input  wire                      pop_in,
  output reg  [7:0]                rdata_out,
  // Fill level
  output reg  [`ECPCR_CNT_W-1:0]   count_out
);
  reg [7:0]               mem [0:`ECPCR_FIFO_DEPTH-1]; // Byte store
  reg [`ECPCR_FIFO_AW-1:0] wptr;                        // Write pointer
  reg [`ECPCR_FIFO_AW-1:0] rptr;                        // Read pointer
  reg [7:0]               last;                        // Last popped byte
  wire full  = (count_out == `ECPCR_FIFO_DEPTH);
  wire empty = (count_out == {`ECPCR_CNT_W{1'b0}});
  wire do_push = push_in & ~full;  // Full FIFO refuses new bytes
  wire do_pop  = pop_in & ~empty;  // Empty read keeps last byte

  // Storage write
  always @(posedge clk_in) begin
    if (do_push) begin
      mem[wptr] <= wdata_in;
    end
  end

  // Head byte shows ahead of the pop; a dry FIFO repeats the last one
  always @* begin
    rdata_out = empty ? last : mem[rptr];
  end

  // Pointers, level and last popped byte
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wptr      <= {`ECPCR_FIFO_AW{1'b0}};
      rptr      <= {`ECPCR_FIFO_AW{1'b0}};
      count_out <= {`ECPCR_CNT_W{1'b0}};
      last      <= 8'h00;
    end else if (clear_in) begin
      wptr      <= {`ECPCR_FIFO_AW{1'b0}};
      rptr      <= {`ECPCR_FIFO_AW{1'b0}};
      count_out <= {`ECPCR_CNT_W{1'b0}};
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr      <= rptr + 1'b1;
        last      <= mem[rptr];
      end
      if (do_push & ~do_pop) begin
        count_out <= count_out + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_out <= count_out - 1'b1;
      end
    end
  end
endmodule

// ===== src/ecpcr_port.v
// Purpose: extended control of a host parallel port with ECP FIFO
// Assumes: CPU port bus synchronous to CORE_CLK_IN, one access a cycle
// Notes:   read data is registered, valid the cycle after RD strobe
`timescale 1ns/1ps
`include "ecpcr_defs.vh"
module ecpcr_port (
  // Clock and reset
  input  wire       CORE_CLK_IN,
  input  wire       RST_IN,
  // CPU register port
  input  wire       UPPER_SEL_IN,     // High selects FIFO/ECR window
  input  wire [2:0] ADDR_IN,
  input  wire       WR_IN,
  input  wire       RD_IN,
  input  wire [7:0] WDATA_IN,
  output reg  [7:0] RDATA_OUT,
  // DMA
  output reg        DMA_REQ_OUT,
  input  wire       DMA_ACK_IN,
  input  wire       DMA_TC_IN,
  // Interrupt
  output reg        IRQ_OUT,
  // Printer pins
  input  wire [7:0] PRINTER_DATA_LINES_IN,
  output reg  [7:0] PRINTER_DATA_LINES_OUT,
  output reg        PRINTER_DATA_LINES_OE_OUT,
  output reg        HOST_STROBE_LINE_OUT,
  output reg        HOST_ACK_LINE_OUT,
  input  wire       PERIPHERAL_ACK_LINE_IN,
  input  wire       PERIPHERAL_BUSY_IN,
  input  wire       PERIPHERAL_FAULT_N_IN
);
  // Registers
  reg [2:0] mode;                   // Operating mode
  reg       fault_irq_enable_n;     // Active-low fault interrupt enable
  reg       block_transfer_enable;  // DMA enable
  reg       service_request_mask;   // Service bit
  reg [5:0] ctrl;                   // Control register bits 5..0
  reg [7:0] data_latch;             // Data port latch
  reg       fault_q;                // Delayed fault input
  reg       ack_q;                  // Delayed acknowledge input
  reg [5:0] dma_run;                // Consecutive request cycles
  reg [3:0] hs_state;               // Handshake state
  reg [7:0] tx_byte;                // Byte on the lines
  reg       tx_cmd;                 // Byte is a command

  // Handshake states, one-hot
  localparam HS_IDLE = 4'b0001;
  localparam HS_LOAD = 4'b0010;
  localparam HS_STRB = 4'b0100;
  localparam HS_WAIT = 4'b1000;

  // Decoded access strobes
  wire wr_ecr  = WR_IN & UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_ECR);
  wire rd_ecr  = RD_IN & UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_ECR);
  wire wr_fifo = WR_IN & UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_FIFO);
  wire rd_fifo = RD_IN & UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_FIFO);
  wire wr_cmdq = WR_IN & ~UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_DATA);
  wire wr_data = WR_IN & ~UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_DATA);
  wire wr_ctrl = WR_IN & ~UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_CTRL);
  wire rd_data = RD_IN & ~UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_DATA);
  wire rd_ctrl = RD_IN & ~UPPER_SEL_IN & (ADDR_IN == `ECPCR_OFS_CTRL);

  // Mode decode
  wire m_std  = (mode == `ECPCR_MODE_STD);
  wire m_bi   = (mode == `ECPCR_MODE_BIDIR);
  wire m_fifo = (mode == `ECPCR_MODE_FIFO);
  wire m_ecp  = (mode == `ECPCR_MODE_ECP);
  wire m_test = (mode == `ECPCR_MODE_TEST);
  wire m_cfg  = (mode == `ECPCR_MODE_CONFIG);
  wire dir_rev = ctrl[`ECPCR_DCR_DIR] & ~m_std & ~m_fifo;

  // FIFO level and status
  wire [`ECPCR_CNT_W-1:0] level;
  wire [7:0]              fifo_q;
  localparam [`ECPCR_CNT_W-1:0] DEPTH_W = `ECPCR_FIFO_DEPTH; // Level width
  wire [`ECPCR_CNT_W-1:0] free = DEPTH_W - level;
  wire f_full  = (level == `ECPCR_FIFO_DEPTH);
  wire f_empty = (level == {`ECPCR_CNT_W{1'b0}});

  // Tag bit rides beside each byte so queues share one FIFO
  reg  [`ECPCR_FIFO_DEPTH-1:0] tag_mem;
  reg  [`ECPCR_FIFO_AW-1:0]    tag_wp;
  reg  [`ECPCR_FIFO_AW-1:0]    tag_rp;

  // Receive strobe from peripheral ack in ECP reverse
  wire ack_rise = PERIPHERAL_ACK_LINE_IN & ~ack_q;
  wire ack_fall = ~PERIPHERAL_ACK_LINE_IN & ack_q;
  wire rx_push  = m_ecp & dir_rev & ack_fall & ~f_full;

  // DMA cycle and pushes/pops
  wire dma_go   = block_transfer_enable & ~service_request_mask;
  wire dma_cyc  = DMA_REQ_OUT & DMA_ACK_IN;
  wire [`ECPCR_CNT_W-1:0] in_flight = {{(`ECPCR_CNT_W-1){1'b0}}, dma_cyc};
  wire dma_room = dir_rev ? (level > in_flight) : (free > in_flight);
  wire host_fwd = (m_fifo | m_ecp) & ~dir_rev;
  wire cmd_push = wr_cmdq & m_ecp & ~dir_rev;
  wire dat_push = (wr_fifo & (host_fwd | m_test))
                | (dma_cyc & ~dir_rev);
  wire hs_pop   = (hs_state == HS_IDLE) & host_fwd & ~f_empty
                & ~PERIPHERAL_BUSY_IN;
  wire host_pop = (rd_fifo & ((m_ecp & dir_rev) | m_test))
                | (dma_cyc & dir_rev);
  wire push     = cmd_push | dat_push | rx_push;
  wire [7:0] push_d = rx_push ? PRINTER_DATA_LINES_IN : WDATA_IN;
  wire pop      = hs_pop | host_pop;

  // Shared FIFO, held clear in standard mode
  ecpcr_fifo u_fifo (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .clear_in  (m_std),
    .push_in   (push),
    .wdata_in  (push_d),
    .pop_in    (pop),
    .rdata_out (fifo_q),
    .count_out (level)
  );

  // Service, fault and acknowledge interrupt events
  wire svc_tc  = block_transfer_enable & dma_cyc & DMA_TC_IN;
  wire svc_wr  = ~block_transfer_enable & ~dir_rev & host_fwd
               & (free >= `ECPCR_WR_THRESH);
  wire svc_rd  = ~block_transfer_enable & dir_rev & m_ecp
               & (level >= `ECPCR_RD_THRESH);
  wire svc_evt = ~service_request_mask & (svc_tc | svc_wr | svc_rd);
  wire flt_wr  = wr_ecr & fault_irq_enable_n & ~WDATA_IN[`ECPCR_ECR_FAULTN]
               & (WDATA_IN[7:5] == `ECPCR_MODE_ECP);
  wire flt_evt = ~PERIPHERAL_FAULT_N_IN
               & ((m_ecp & ~fault_irq_enable_n & fault_q) | flt_wr);
  wire ack_evt = ctrl[`ECPCR_DCR_ACKIE] & ack_rise;

  // Extended control and mode register
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode                  <= `ECPCR_MODE_STD;
      fault_irq_enable_n    <= 1'b1;
      block_transfer_enable <= 1'b0;
      service_request_mask  <= 1'b1;
    end else begin
      if (wr_ecr) begin
        mode                  <= WDATA_IN[7:5];
        fault_irq_enable_n    <= WDATA_IN[`ECPCR_ECR_FAULTN];
        block_transfer_enable <= WDATA_IN[`ECPCR_ECR_BLOCK_TRANSFER_ENABLE];
      end
      // Hardware set wins over a software clear
      if (svc_evt) begin
        service_request_mask <= 1'b1;
      end else if (wr_ecr) begin
        service_request_mask <= WDATA_IN[`ECPCR_ECR_SERV];
      end
    end
  end

  // Control register and data latch
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl       <= 6'h00;
      data_latch <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= WDATA_IN[5:0];
        // Direction only writable from bidirectional mode
        if (!m_bi) begin
          ctrl[`ECPCR_DCR_DIR] <= ctrl[`ECPCR_DCR_DIR];
        end
      end else if (m_std) begin
        ctrl[`ECPCR_DCR_DIR] <= 1'b0;
      end
      if (wr_data & (m_std | m_bi)) begin
        data_latch <= WDATA_IN;
      end
    end
  end

  // Input edge history
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fault_q <= 1'b1;
      ack_q   <= 1'b1;
    end else begin
      fault_q <= PERIPHERAL_FAULT_N_IN;
      ack_q   <= PERIPHERAL_ACK_LINE_IN;
    end
  end

  // Tag memory marks command bytes
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tag_mem <= {`ECPCR_FIFO_DEPTH{1'b0}};
      tag_wp  <= {`ECPCR_FIFO_AW{1'b0}};
      tag_rp  <= {`ECPCR_FIFO_AW{1'b0}};
    end else if (m_std) begin
      tag_wp <= {`ECPCR_FIFO_AW{1'b0}};
      tag_rp <= {`ECPCR_FIFO_AW{1'b0}};
    end else begin
      if (push & ~f_full) begin
        tag_mem[tag_wp] <= cmd_push;
        tag_wp          <= tag_wp + 1'b1;
      end
      if (pop & ~f_empty) begin
        tag_rp <= tag_rp + 1'b1;
      end
    end
  end

  // Forward handshake engine
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hs_state <= HS_IDLE;
      tx_byte  <= 8'h00;
      tx_cmd   <= 1'b0;
    end else begin
      case (hs_state)
        HS_IDLE: begin
          if (hs_pop) begin
            tx_cmd   <= tag_mem[tag_rp];
            tx_byte  <= fifo_q;  // Head byte leaves with its tag
            hs_state <= HS_LOAD;
          end
        end
        HS_LOAD: begin
          hs_state <= HS_STRB;
        end
        HS_STRB: begin
          if (PERIPHERAL_BUSY_IN | m_fifo) begin
            hs_state <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!PERIPHERAL_BUSY_IN) begin
            hs_state <= HS_IDLE;
          end
        end
        default: begin
          hs_state <= HS_IDLE;
        end
      endcase
      // Leaving the automatic modes abandons the transfer
      if (!host_fwd) begin
        hs_state <= HS_IDLE;
      end
    end
  end

  // DMA request with a cap on consecutive cycles
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DMA_REQ_OUT <= 1'b0;
      dma_run     <= 6'h00;
    end else begin
      if (dma_go & (m_fifo | m_ecp | m_test)
          & (dma_run < `ECPCR_DMA_BURST) & ~svc_tc
          & dma_room) begin
        DMA_REQ_OUT <= 1'b1;
        dma_run     <= dma_run + 6'h01;
      end else begin
        DMA_REQ_OUT <= 1'b0;
        dma_run     <= 6'h00;
      end
    end
  end

  // Pin drivers
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PRINTER_DATA_LINES_OUT    <= 8'h00;
      PRINTER_DATA_LINES_OE_OUT <= 1'b1;
      HOST_STROBE_LINE_OUT      <= 1'b1;
      HOST_ACK_LINE_OUT         <= 1'b1;
      IRQ_OUT                   <= 1'b0;
    end else begin
      PRINTER_DATA_LINES_OE_OUT <= ~dir_rev;
      if (host_fwd & (hs_state != HS_IDLE)) begin
        PRINTER_DATA_LINES_OUT <= tx_byte;
        HOST_STROBE_LINE_OUT   <= (hs_state != HS_STRB);
        HOST_ACK_LINE_OUT      <= ~(m_ecp & tx_cmd);
      end else if (m_ecp & dir_rev & ~wr_ecr) begin
        HOST_STROBE_LINE_OUT <= 1'b1;
        HOST_ACK_LINE_OUT    <= f_full | ~ack_q;
      end else if (m_ecp & dir_rev) begin
        HOST_ACK_LINE_OUT <= 1'b1;
      end else begin
        // Test mode shows FIFO output; strobe follows the control strobe bit
        PRINTER_DATA_LINES_OUT <= m_test ? fifo_q : data_latch;
        HOST_STROBE_LINE_OUT   <= ~ctrl[`ECPCR_DCR_STROBE];
        HOST_ACK_LINE_OUT      <= ~ctrl[`ECPCR_DCR_AUTOFD];
      end
      IRQ_OUT <= svc_evt | flt_evt | ack_evt;
    end
  end

  // Read data mux
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (rd_ecr) begin
      RDATA_OUT <= {mode, fault_irq_enable_n, block_transfer_enable,
                    service_request_mask, f_full, f_empty};
    end else if (UPPER_SEL_IN & RD_IN & m_cfg) begin
      RDATA_OUT <= (ADDR_IN == `ECPCR_OFS_CFGB) ? `ECPCR_CFG_B
                                                : `ECPCR_CFG_A;
    end else if (rd_fifo) begin
      RDATA_OUT <= fifo_q;
    end else if (rd_data) begin
      RDATA_OUT <= dir_rev ? PRINTER_DATA_LINES_IN : data_latch;
    end else if (rd_ctrl) begin
      RDATA_OUT <= {2'b11, ctrl};
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end
endmodule

// ===== test/ecpcr_periph_model.sv
// Purpose: behavioural printer side for the ECP port bench
// Assumes: host lines come from the design on the bench clock
// Notes:   slow stretches busy and delays acknowledge by that many cycles
`timescale 1ns/1ps
module ecpcr_periph_model (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic       hack_n,
  input  wire logic [7:0] host_d,
  input  wire logic       rev_en,
  input  wire logic [3:0] slow,
  output logic            busy,
  output logic            ack_n,
  output logic [7:0]      pins,
  output logic [7:0]      rev_n
);
  logic [7:0] got_q[$];  // Bytes taken in the forward direction
  logic       cmd_q[$];  // Host acknowledge low beside each byte
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    pins = 8'h5A;
    rev_n = 8'h00;
  end
  // Take the byte on strobe, then hold busy
  always @(negedge strobe_n) begin
    #1 got_q.push_back(host_d);
    cmd_q.push_back(!hack_n);
    busy = 1'b1;
    repeat (slow + 1) @(posedge clk);
    #1 busy = 1'b0;
  end
  // Answer each host request with the next byte, then let go
  always begin
    wait (rev_en && !hack_n);
    @(posedge clk) #1 pins = 8'hA0 + rev_n;
    repeat (slow) @(posedge clk);
    #1 ack_n = 1'b0;
    wait (hack_n);
    @(posedge clk) #1 ack_n = 1'b1;
    rev_n = rev_n + 8'h01;
    pins = ~pins;  // Released lines do not keep the old byte
  end
endmodule

// ===== test/ecpcr_port_sva.sv
// Purpose: port-level checker of the ECP port control block
// Assumes: one clock; host register writes are shadowed here
// Notes:   bound to the top module from the bench top file
`timescale 1ns/1ps
`include "ecpcr_defs.vh"
module ecpcr_port_sva (
  // Clock, reset and register port
  input wire logic       CORE_CLK_IN, RST_IN, UPPER_SEL_IN, WR_IN, RD_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN, RDATA_OUT,
  // DMA, interrupt and printer side
  input wire logic       DMA_REQ_OUT, DMA_ACK_IN, DMA_TC_IN, IRQ_OUT,
  input wire logic       PRINTER_DATA_LINES_OE_OUT, HOST_ACK_LINE_OUT,
  input wire logic       PERIPHERAL_ACK_LINE_IN, PERIPHERAL_FAULT_N_IN
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  reg  [7:0] ecr_q;  // Last written extended control
  reg  [7:0] dcr_q;  // Last written control, direction only in 001
  reg  [5:0] run_q;  // Consecutive request cycles so far
  wire       std_m = ecr_q[7:5] == `ECPCR_MODE_STD;
  wire       rev_m = dcr_q[5] && (ecr_q[7:5] == `ECPCR_MODE_BIDIR ||
                                  ecr_q[7:5] == `ECPCR_MODE_ECP);
  wire       no_dma = !ecr_q[3] || ecr_q[2];  // Disabled or masked
  // Shadows follow host writes; direction is refused outside 001
  always @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ecr_q <= `ECPCR_ECR_RESET;
      dcr_q <= 8'h00;
      run_q <= 6'h00;
    end else begin
      run_q <= DMA_REQ_OUT ? run_q + 6'h01 : 6'h00;
      if (WR_IN && UPPER_SEL_IN && ADDR_IN == `ECPCR_OFS_ECR)
        ecr_q <= WDATA_IN;
      if (WR_IN && !UPPER_SEL_IN && ADDR_IN == `ECPCR_OFS_CTRL)
        dcr_q <= {WDATA_IN[7:6], ecr_q[7:5] == `ECPCR_MODE_BIDIR ?
                  WDATA_IN[5] : dcr_q[5], WDATA_IN[4:0]};
      else if (std_m)
        dcr_q[5] <= 1'b0;  // Standard mode forces forward
    end
  end
  // Steps of the multi-cycle behaviours
  sequence s_ecr_rd;
    RD_IN && UPPER_SEL_IN && ADDR_IN == `ECPCR_OFS_ECR;
  endsequence
  sequence s_tc;
    DMA_REQ_OUT && DMA_ACK_IN && DMA_TC_IN;
  endsequence
  sequence s_leave_rev;
    WR_IN && UPPER_SEL_IN && ADDR_IN == `ECPCR_OFS_ECR &&
    WDATA_IN[7:5] != ecr_q[7:5] && ecr_q[7:5] == `ECPCR_MODE_ECP;
  endsequence
  a_dma_burst_cap: assert property (DMA_REQ_OUT |-> run_q < 6'h20)
    else $error("DMA request held beyond burst cap");
  a_tc_raises_irq: assert property (s_tc |-> ##[1:3] IRQ_OUT)
    else $error("No interrupt after terminal count");
  a_tc_stops_dma: assert property (s_tc |=> ##[0:2] (!DMA_REQ_OUT) [*4])
    else $error("DMA request goes on after terminal count");
  a_dma_gated_off: assert property (no_dma && $past(no_dma) |-> !DMA_REQ_OUT)
    else $error("DMA request while disabled or masked");
  a_mode_drops_ack: assert property (s_leave_rev ##0 (dcr_q[5] && !dcr_q[1])
    |-> ##[1:2] HOST_ACK_LINE_OUT)
    else $error("Host acknowledge kept after mode change");
  a_std_drives_bus: assert property (std_m && $past(std_m)
    |-> PRINTER_DATA_LINES_OE_OUT)
    else $error("Data lines released in standard mode");
  a_rev_frees_bus: assert property (rev_m && $past(rev_m)
    |-> !PRINTER_DATA_LINES_OE_OUT)
    else $error("Data lines driven in reverse direction");
  a_std_ecr_read: assert property (s_ecr_rd ##0 (std_m && $past(std_m))
    |=> RDATA_OUT[7:5] == 3'h0 && RDATA_OUT[1:0] == 2'h1)
    else $error("Standard mode status not empty");
  a_cfg_a_read: assert property (RD_IN && UPPER_SEL_IN && !ADDR_IN[0] &&
    !ADDR_IN[1] && ecr_q[7:5] == `ECPCR_MODE_CONFIG
    |=> RDATA_OUT == `ECPCR_CFG_A)
    else $error("Configuration word A wrong");
  a_fault_irq: assert property (ecr_q[7:5] == `ECPCR_MODE_ECP && !ecr_q[4]
    && $fell(PERIPHERAL_FAULT_N_IN) |-> ##[1:3] IRQ_OUT)
    else $error("No interrupt on fault edge");
  a_ack_edge_irq: assert property (dcr_q[4] && $rose(PERIPHERAL_ACK_LINE_IN)
    |-> ##[1:4] IRQ_OUT)
    else $error("No interrupt on acknowledge edge");
endmodule

// ===== test/test_ecp_parallel_port_control.sv
// Purpose: self-checking bench of the ECP port control block
// Assumes: bench drives inputs at the falling clock edge
// Notes:   random bytes from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`include "ecpcr_defs.vh"
module test_ecp_parallel_port_control;
  logic clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, ack = 0, tc = 0;
  logic tb_ack_n = 1, fault_n = 1, rev_en = 0;
  logic [2:0] addr = 0;
  logic [3:0] slow = 0;
  logic [7:0] wd = 0, b;
  logic [7:0] exp_q[$];  // Bytes the printer or a host FIFO read should see
  wire  [7:0] rdata, pd_out, pm_pins, rev_n, pins_in;
  wire  dreq, irq, oe, strobe_n, hack_n, pack_n, busy;
  int   errors = 0, tests_run = 0, irqs = 0, k, n0;
  assign pins_in = oe ? pd_out : pm_pins;  // Bus level from both drivers
  always #20 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irqs++;
  ecpcr_port dut_u (
    .CORE_CLK_IN(clk), .RST_IN(rst), .UPPER_SEL_IN(sel), .ADDR_IN(addr),
    .WR_IN(wr), .RD_IN(rd), .WDATA_IN(wd), .RDATA_OUT(rdata),
    .DMA_REQ_OUT(dreq), .DMA_ACK_IN(ack), .DMA_TC_IN(tc), .IRQ_OUT(irq),
    .PRINTER_DATA_LINES_IN(pins_in), .PRINTER_DATA_LINES_OUT(pd_out),
    .PRINTER_DATA_LINES_OE_OUT(oe), .HOST_STROBE_LINE_OUT(strobe_n),
    .HOST_ACK_LINE_OUT(hack_n), .PERIPHERAL_ACK_LINE_IN(pack_n & tb_ack_n),
    .PERIPHERAL_BUSY_IN(busy), .PERIPHERAL_FAULT_N_IN(fault_n));
  ecpcr_periph_model pm (.clk(clk), .strobe_n(strobe_n), .hack_n(hack_n),
    .host_d(pd_out), .rev_en(rev_en), .slow(slow), .busy(busy),
    .ack_n(pack_n), .pins(pm_pins), .rev_n(rev_n));
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register access; read data is settled at the return
  task automatic acc(input logic s, w, input logic [2:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    sel = s; addr = a; wd = d; wr = w; rd = !w;
    @(negedge clk);
    wr = 0; rd = 0;
  endtask
  task automatic rd_chk(input logic s, input logic [2:0] a,
                        input logic [7:0] e);
    acc(s, 0, a, 8'h00);
    check("read", rdata, e);
  endtask
  // Wait for the printer, then compare every byte in order
  task automatic fwd_check(input int n);
    for (int i = 0; i < 3000 && pm.got_q.size() < n; i++) @(negedge clk);
    repeat (n) check("fwd byte", pm.got_q.pop_front(), exp_q.pop_front());
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    void'($urandom(29));
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    rd_chk(1, `ECPCR_OFS_ECR, `ECPCR_ECR_RESET);
    $display("reset test done");
    // Direction refused in 000, honoured in 001
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h20);
    check("oe std", oe, 1'h1);
    acc(1, 1, `ECPCR_OFS_ECR, 8'h34);
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h20);
    @(negedge clk);
    check("oe rev", oe, 1'h0);
    acc(0, 0, `ECPCR_OFS_DATA, 8'h00);
    check("pin read", rdata, pins_in);
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h00);
    $display("direction test done");
    // ECP forward: data and command bytes interleaved, fault edge
    slow = 4'($urandom_range(3, 0));
    acc(1, 1, `ECPCR_OFS_ECR, 8'h60);
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      acc(i != 3, 1, `ECPCR_OFS_FIFO, b);
    end
    n0 = irqs;
    fault_n = 0;
    repeat (4) @(negedge clk);
    fault_n = 1;
    check("fault irq", 8'(irqs - n0), 8'h01);
    fwd_check(6);
    for (int i = 0; i < 6; i++)
      check("cmd flag", 8'(pm.cmd_q.pop_front()), 8'(i == 3));
    rd_chk(1, `ECPCR_OFS_ECR, 8'h65);
    acc(1, 1, `ECPCR_OFS_ECR, 8'h34);
    $display("ecp forward test done");
    // Test mode: fill past full, drain past empty, nothing sent
    acc(1, 1, `ECPCR_OFS_ECR, 8'hD4);
    for (int i = 0; i <= `ECPCR_FIFO_DEPTH; i++) begin
      b = 8'($urandom);
      if (i < `ECPCR_FIFO_DEPTH) exp_q.push_back(b);
      acc(1, 1, `ECPCR_OFS_FIFO, b);
    end
    rd_chk(1, `ECPCR_OFS_ECR, 8'hD6);
    repeat (`ECPCR_FIFO_DEPTH) begin
      b = exp_q.pop_front();
      rd_chk(1, `ECPCR_OFS_FIFO, b);
    end
    rd_chk(1, `ECPCR_OFS_FIFO, b);
    rd_chk(1, `ECPCR_OFS_ECR, 8'hD5);
    check("not sent", 8'(pm.got_q.size()), 8'h00);
    acc(1, 1, `ECPCR_OFS_ECR, 8'hF4);
    rd_chk(1, `ECPCR_OFS_FIFO, `ECPCR_CFG_A);
    rd_chk(1, `ECPCR_OFS_CFGB, `ECPCR_CFG_B);
    acc(1, 1, `ECPCR_OFS_ECR, 8'h34);
    $display("test and config test done");
    // ECP reverse: fill, interrupt, drain while filling, leave mid-way
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h20);
    n0 = irqs;
    acc(1, 1, `ECPCR_OFS_ECR, 8'h70);
    rev_en = 1;
    for (int i = 0; i < 3000 && rev_n < 8'h08; i++) @(negedge clk);
    check("rev irq", 8'(irqs > n0), 8'h01);
    for (int i = 0; i < 4; i++) rd_chk(1, `ECPCR_OFS_FIFO, 8'hA0 + i);
    rev_en = 0;
    repeat (20) @(negedge clk);
    repeat (`ECPCR_FIFO_DEPTH) acc(1, 0, `ECPCR_OFS_FIFO, 8'h00);
    acc(1, 1, `ECPCR_OFS_ECR, 8'h34);
    @(negedge clk);
    check("host ack idle", hack_n, 1'h1);
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h00);
    $display("ecp reverse test done");
    // FIFO mode with DMA up to terminal count
    slow = 0;
    k = 0;
    acc(1, 1, `ECPCR_OFS_ECR, 8'h48);
    for (int i = 0; i < 2000 && k < 20; i++) begin
      @(negedge clk);
      ack = dreq === 1'b1;
      tc = ack && k == 19;
      wd = 8'($urandom);
      if (ack) exp_q.push_back(wd);
      if (ack) k++;
    end
    @(negedge clk);
    ack = 0;
    tc = 0;
    repeat (10) @(negedge clk);
    check("dma stopped", dreq, 1'h0);
    acc(1, 0, `ECPCR_OFS_ECR, 8'h00);
    check("service set", rdata & 8'hEC, 8'h4C);
    fwd_check(20);
    acc(1, 1, `ECPCR_OFS_ECR, 8'h44);
    $display("dma test done");
    // Acknowledge edge interrupt in standard mode
    acc(1, 1, `ECPCR_OFS_ECR, 8'h14);
    acc(0, 1, `ECPCR_OFS_CTRL, 8'h10);
    n0 = irqs;
    tb_ack_n = 0;
    repeat (2) @(negedge clk);
    tb_ack_n = 1;
    repeat (6) @(negedge clk);
    check("ack irq", 8'(irqs - n0), 8'h01);
    $display("ack interrupt test done");
    final_report;
  end
endmodule
bind ecpcr_port ecpcr_port_sva chk_u (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .UPPER_SEL_IN(UPPER_SEL_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .RDATA_OUT(RDATA_OUT), .DMA_REQ_OUT(DMA_REQ_OUT), .DMA_ACK_IN(DMA_ACK_IN),
  .DMA_TC_IN(DMA_TC_IN), .IRQ_OUT(IRQ_OUT),
  .PRINTER_DATA_LINES_OE_OUT(PRINTER_DATA_LINES_OE_OUT),
  .HOST_ACK_LINE_OUT(HOST_ACK_LINE_OUT),
  .PERIPHERAL_ACK_LINE_IN(PERIPHERAL_ACK_LINE_IN),
  .PERIPHERAL_FAULT_N_IN(PERIPHERAL_FAULT_N_IN));
